// file: logic/qst_status_tree.sv
// questionable status tree: per-output regulation, output-fault and questionable registers
`timescale 1ns/1ps
`include "qst_regs.svh"

// Functional notes
// - event bits latch until explicitly cleared
// - reading an event register clears it
// - clear-status clears events, keeps enable masks
// - device reset and clear leave events alone
// - read value is binary weighted bit sum
// - summary is OR of events AND enables
// - enable masks read/write, reading leaves them intact
// - output summaries feed fault register, fault summary sets questionable bit 13
// - fan fault sets questionable bit 4
// - questionable register 16 bits, others zero
// - fault bit 1 first output, bit 2 second
// - regulation bit 0 voltage, bit 1 current lost
// - regulation bit 9 on overvoltage trip
// - condition bits give live cv/cc mode
// - writing zero clears questionable enable mask
// - questionable summary drives status byte bit 3
// - status byte summary bits never latch

module qst_status_tree #(
	parameter int WIDTH = 16,
	parameter int OUTPUTS = 2
) (
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic [OUTPUTS-1:0] constant_voltage, // per-output cv mode flags
	input wire logic [OUTPUTS-1:0] constant_current, // per-output cc mode flags
	input wire logic [OUTPUTS-1:0] overvoltage_trip, // per-output overvoltage trip flags
	input wire logic fan_fault, // cooling fan fault level
	input wire logic clear_status, // clear-status command pulse
	input wire logic device_clear, // device clear or reset command pulse, no effect on events
	input wire logic req_valid, // register access request pulse
	input wire logic req_write, // 1 write, 0 read
	input wire logic [2:0] req_sel, // register selector
	input wire logic req_output, // output index for per-output registers
	input wire logic [WIDTH-1:0] req_wdata, // write data
	output logic rsp_valid, // read data valid pulse
	output logic [WIDTH-1:0] rsp_rdata, // read data
	output logic [7:0] status_byte, // status byte summary, bit 3 used
	output logic questionable_summary_bit // masked questionable summary
);
	logic [OUTPUTS-1:0] reg_clear;
	logic [OUTPUTS-1:0] reg_enable_we;
	logic [OUTPUTS-1:0] output_regulation_summary;
	logic [WIDTH-1:0] reg_event [OUTPUTS];
	logic [WIDTH-1:0] reg_enable [OUTPUTS];
	logic [WIDTH-1:0] reg_cond [OUTPUTS];
	logic [WIDTH-1:0] questionable_event_reg;
	logic [WIDTH-1:0] questionable_enable_reg;
	logic [WIDTH-1:0] output_fault_event_reg;
	logic [WIDTH-1:0] output_fault_enable_reg;
	logic [WIDTH-1:0] fault_cause;
	logic [WIDTH-1:0] questionable_summary_bit_cause;
	logic [WIDTH-1:0] questionable_summary_bit_level;
	logic [WIDTH-1:0] questionable_summary_bit_level_reg;
	logic [WIDTH-1:0] fault_level_reg;
	logic [WIDTH-1:0] rdata_next;
	logic fault_summary;
	logic questionable_summary_bit_summary_next;
	qst_pkg::qst_access_t access;
	logic rd;
	logic wr;
	logic rd_questionable_summary_bit_event;
	logic rd_fault_event;
	logic rd_reg_event;
	logic wr_questionable_summary_bit_enable;
	logic wr_fault_enable;
	logic wr_reg_enable;
	logic clr_questionable_summary_bit_event;
	logic clr_fault_event;

	always_comb begin
		if (req_valid && req_write)
			access = qst_pkg::QST_WRITE;
		else if (req_valid)
			access = qst_pkg::QST_READ;
		else
			access = qst_pkg::QST_IDLE;
	end

	assign rd = (access == qst_pkg::QST_READ);
	assign wr = (access == qst_pkg::QST_WRITE);

	// one strobe per register action, so every latch and mask sees the same decode
	always_comb begin
		rd_questionable_summary_bit_event = 1'b0;
		rd_fault_event = 1'b0;
		rd_reg_event = 1'b0;
		wr_questionable_summary_bit_enable = 1'b0;
		wr_fault_enable = 1'b0;
		wr_reg_enable = 1'b0;
		case (access)
			qst_pkg::QST_READ: begin
				case (req_sel)
					`QST_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT: rd_questionable_summary_bit_event = 1'b1;
					`QST_SEL_FAULT_EVENT: rd_fault_event = 1'b1;
					`QST_SEL_REG_EVENT: rd_reg_event = 1'b1;
					default: rd_reg_event = 1'b0;
				endcase
			end
			qst_pkg::QST_WRITE: begin
				// writes to event and condition selectors are ignored
				case (req_sel)
					`QST_SEL_QUESTIONABLE_SUMMARY_BIT_ENABLE: wr_questionable_summary_bit_enable = 1'b1;
					`QST_SEL_FAULT_ENABLE: wr_fault_enable = 1'b1;
					`QST_SEL_REG_ENABLE: wr_reg_enable = 1'b1;
					default: wr_reg_enable = 1'b0;
				endcase
			end
			default: rd_reg_event = 1'b0;
		endcase
	end

	// device_clear deliberately absent from every clear term
	assign clr_questionable_summary_bit_event = clear_status | rd_questionable_summary_bit_event;
	assign clr_fault_event = clear_status | rd_fault_event;

	genvar g;
	generate
		for (g = 0; g < OUTPUTS; g++) begin : g_out
			// device_clear deliberately absent from the clear term
			assign reg_clear[g] = clear_status | (rd_reg_event && req_output == g);
			assign reg_enable_we[g] = wr_reg_enable && req_output == g;
			qst_output_summary #(
				.WIDTH(WIDTH)
			) u_out (
				.clk(clk),
				.nrst(nrst),
				.constant_voltage(constant_voltage[g]),
				.constant_current(constant_current[g]),
				.overvoltage_trip(overvoltage_trip[g]),
				.clear_events(reg_clear[g]),
				.enable_we(reg_enable_we[g]),
				.enable_wdata(req_wdata),
				.event_q(reg_event[g]),
				.enable_q(reg_enable[g]),
				.cond_q(reg_cond[g]),
				.summary(output_regulation_summary[g])
			);
		end
	endgenerate

	// output-fault levels: bit 1 first output, bit 2 second
	always_comb begin
		fault_cause = `QST_ZERO16;
		fault_cause[`QST_BIT_OUT1 +: OUTPUTS] = output_regulation_summary;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			fault_level_reg <= `QST_ZERO16;
		else
			fault_level_reg <= fault_cause;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			output_fault_event_reg <= `QST_ZERO16;
		else if (clr_fault_event)
			output_fault_event_reg <= fault_cause & ~fault_level_reg;
		else
			output_fault_event_reg <= output_fault_event_reg |
				(fault_cause & ~fault_level_reg);
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			output_fault_enable_reg <= `QST_ZERO16;
		else if (wr_fault_enable)
			output_fault_enable_reg <= req_wdata;
	end

	assign fault_summary = |(output_fault_event_reg & output_fault_enable_reg);

	// questionable levels: only fan and output summary positions exist
	always_comb begin
		questionable_summary_bit_level = `QST_ZERO16;
		questionable_summary_bit_level[`QST_BIT_FAN] = fan_fault;
		questionable_summary_bit_level[`QST_BIT_OUTSUM] = fault_summary;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			questionable_summary_bit_level_reg <= `QST_ZERO16;
		else
			questionable_summary_bit_level_reg <= questionable_summary_bit_level;
	end

	assign questionable_summary_bit_cause = questionable_summary_bit_level & ~questionable_summary_bit_level_reg;

	always_ff @(posedge clk) begin
		if (!nrst)
			questionable_event_reg <= `QST_ZERO16;
		else if (clr_questionable_summary_bit_event)
			questionable_event_reg <= questionable_summary_bit_cause; // set wins over clear
		else
			questionable_event_reg <= questionable_event_reg | questionable_summary_bit_cause;
	end

	// written value stored whole, so zero clears the mask
	always_ff @(posedge clk) begin
		if (!nrst)
			questionable_enable_reg <= `QST_ZERO16;
		else if (wr_questionable_summary_bit_enable)
			questionable_enable_reg <= req_wdata;
	end

	// computed from the next event value so a read-clear drops the summary at once
	always_comb begin
		questionable_summary_bit_summary_next = |(questionable_event_reg & questionable_enable_reg);
		if (clr_questionable_summary_bit_event)
			questionable_summary_bit_summary_next = |(questionable_summary_bit_cause & questionable_enable_reg);
		else if (wr_questionable_summary_bit_enable)
			questionable_summary_bit_summary_next = |((questionable_event_reg | questionable_summary_bit_cause) & req_wdata);
		else
			questionable_summary_bit_summary_next = |((questionable_event_reg | questionable_summary_bit_cause) &
				questionable_enable_reg);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			questionable_summary_bit <= 1'b0;
			status_byte <= `QST_ZERO8;
		end else begin
			questionable_summary_bit <= questionable_summary_bit_summary_next;
			status_byte <= `QST_ZERO8;
			status_byte[`QST_BIT_STB_QUESTIONABLE_SUMMARY_BIT] <= questionable_summary_bit_summary_next;
		end
	end

	// read data is the register word itself, i.e. the weighted bit sum
	always_comb begin
		case (req_sel)
			`QST_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT: rdata_next = questionable_event_reg;
			`QST_SEL_QUESTIONABLE_SUMMARY_BIT_ENABLE: rdata_next = questionable_enable_reg;
			`QST_SEL_FAULT_EVENT: rdata_next = output_fault_event_reg;
			`QST_SEL_FAULT_ENABLE: rdata_next = output_fault_enable_reg;
			`QST_SEL_REG_EVENT: rdata_next = reg_event[req_output];
			`QST_SEL_REG_ENABLE: rdata_next = reg_enable[req_output];
			`QST_SEL_REG_COND: rdata_next = reg_cond[req_output];
			default: rdata_next = `QST_ZERO16;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= `QST_ZERO16;
		end else begin
			rsp_valid <= rd;
			if (rd)
				rsp_rdata <= rdata_next;
		end
	end
endmodule

// file: logic/qst_regs.svh
// register selectors, field positions and reset values of the status tree
`ifndef QST_REGS_SVH
`define QST_REGS_SVH

`define QST_SEL_QUESTIONABLE_SUMMARY_BIT_EVENT 3'h0
`define QST_SEL_QUESTIONABLE_SUMMARY_BIT_ENABLE 3'h1
`define QST_SEL_FAULT_EVENT 3'h2
`define QST_SEL_FAULT_ENABLE 3'h3
`define QST_SEL_REG_EVENT 3'h4
`define QST_SEL_REG_ENABLE 3'h5
`define QST_SEL_REG_COND 3'h6

`define QST_BIT_VUNREG 0
`define QST_BIT_IUNREG 1
`define QST_BIT_OVTRIP 9
`define QST_BIT_FAN 4
`define QST_BIT_OUTSUM 13
`define QST_BIT_OUT1 1
`define QST_BIT_STB_QUESTIONABLE_SUMMARY_BIT 3

`define QST_ZERO16 16'h0000
`define QST_ZERO8 8'h00
`define QST_COND_CV 2'h2
`define QST_COND_CC 2'h1
`define QST_COND_UNREG 2'h3

`endif

// file: logic/qst_pkg.sv
// types shared by the status tree
package qst_pkg;
	typedef enum logic [1:0] {
		QST_IDLE,
		QST_READ,
		QST_WRITE
	} qst_access_t;
endpackage

// file: logic/qst_output_summary.sv
// regulation event, condition and enable registers of one supply output
`timescale 1ns/1ps
`include "qst_regs.svh"

module qst_output_summary #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	input wire logic constant_voltage, // live cv mode flag
	input wire logic constant_current, // live cc mode flag
	input wire logic overvoltage_trip, // live overvoltage protection flag
	input wire logic clear_events, // clear-status or read-clear of the event register
	input wire logic enable_we, // write strobe for the enable mask
	input wire logic [WIDTH-1:0] enable_wdata, // new enable mask
	output logic [WIDTH-1:0] event_q, // latched event bits
	output logic [WIDTH-1:0] enable_q, // enable mask
	output logic [WIDTH-1:0] cond_q, // live condition bits
	output logic summary // masked summary of the event bits
);
	logic [WIDTH-1:0] cause;
	logic [WIDTH-1:0] cause_reg;
	logic [WIDTH-1:0] cause_next;

	// regulation lost: cv-only means voltage ok; cc sets voltage lost, and cc with cv also sets current lost
	always_comb begin
		cause_next = `QST_ZERO16;
		cause_next[`QST_BIT_VUNREG] = constant_current;
		cause_next[`QST_BIT_IUNREG] = constant_current & constant_voltage;
		cause_next[`QST_BIT_OVTRIP] = overvoltage_trip;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			cause_reg <= `QST_ZERO16;
		else
			cause_reg <= cause_next;
	end

	assign cause = cause_next & ~cause_reg;

	always_ff @(posedge clk) begin
		if (!nrst)
			event_q <= `QST_ZERO16;
		else if (clear_events)
			event_q <= cause; // set wins over clear
		else
			event_q <= event_q | cause;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			enable_q <= `QST_ZERO16;
		else if (enable_we)
			enable_q <= enable_wdata;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			cond_q <= `QST_ZERO16;
		else
			cond_q <= {{(WIDTH-2){1'b0}}, constant_voltage, constant_current};
	end

	assign summary = |(event_q & enable_q);
endmodule

// file: verification/qst_status_tree_sva.sv
// port-level assertions for the questionable status tree
`timescale 1ns/1ps
module qst_status_tree_sva #(
	parameter int WIDTH = 16,
	parameter int OUTPUTS = 2
) (
	input wire logic clk, // clock
	input wire logic nrst, // sync reset
	input wire logic [OUTPUTS-1:0] constant_voltage, // cv flags
	input wire logic [OUTPUTS-1:0] constant_current, // cc flags
	input wire logic [OUTPUTS-1:0] overvoltage_trip, // trip flags
	input wire logic fan_fault, // fan fault
	input wire logic clear_status, // clear pulse
	input wire logic device_clear, // device clear pulse
	input wire logic req_valid, // request
	input wire logic req_write, // write flag
	input wire logic [2:0] req_sel, // selector
	input wire logic req_output, // output index
	input wire logic [WIDTH-1:0] req_wdata, // write data
	input wire logic rsp_valid, // answer strobe
	input wire logic [WIDTH-1:0] rsp_rdata, // read data
	input wire logic [7:0] status_byte, // status byte
	input wire logic questionable_summary_bit // summary
);
	logic [3:0] quiet_reg;
	wire [3*OUTPUTS:0] ins = {constant_voltage, constant_current, overvoltage_trip, fan_fault};
	// the event chain needs several settled cycles before summaries can be judged
	always_ff @(posedge clk) begin
		if (!nrst || req_valid || clear_status || !$stable(ins))
			quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hf)
			quiet_reg <= quiet_reg + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_rd4;
		req_valid && !req_write && req_sel == 3'h4 && $stable(ins);
	endsequence
	sequence s_clr;
		clear_status && !req_valid && $stable(ins);
	endsequence
	a_read_answer: assert property (req_valid && !req_write |=> rsp_valid)
		else $error("read not answered");
	a_write_silent: assert property (!(req_valid && !req_write) |=> !rsp_valid)
		else $error("answer without read");
	a_sel7_zero: assert property (req_valid && !req_write && req_sel == 3'h7
		|=> rsp_rdata == 16'h0000)
		else $error("spare selector not zero");
	a_questionable_summary_bit_unused: assert property (req_valid && !req_write && req_sel == 3'h0
		|=> (rsp_rdata & 16'hdfef) == 16'h0000)
		else $error("unused questionable bit set");
	a_cond_live: assert property (req_valid && !req_write && req_sel == 3'h6
		&& !req_output && $stable(ins) ##1 $stable(ins)
		|-> rsp_rdata == {14'h0000, constant_voltage[0], constant_current[0]})
		else $error("condition bits wrong");
	a_stb_bits: assert property (status_byte[7:4] == 4'h0 && status_byte[2:0] == 3'h0
		&& questionable_summary_bit == status_byte[3])
		else $error("status byte bits wrong");
	a_read_clears: assert property (s_rd4 ##1 (s_rd4 and req_output == $past(req_output))
		|=> rsp_rdata == 16'h0000)
		else $error("event survived read");
	a_clear_empties: assert property (s_clr ##1 s_rd4 |=> rsp_rdata == 16'h0000)
		else $error("event survived clear");
	a_stb_unlatched: assert property ((s_clr and quiet_reg > 4'h5) ##1 $stable(ins)
		|-> ##1 !status_byte[3])
		else $error("summary held after clear");
	a_devclr_keeps: assert property (device_clear && quiet_reg > 4'h5 && status_byte[3]
		&& !clear_status && !req_valid && $stable(ins) |=> status_byte[3])
		else $error("device clear lost events");
	a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) !nrst
		|=> !rsp_valid && status_byte == 8'h00)
		else $error("outputs not zero after reset");
endmodule
bind qst_status_tree qst_status_tree_sva #(.WIDTH(WIDTH), .OUTPUTS(OUTPUTS)) i_sva (.*);

// file: verification/questionable_status_tree_tb.sv
// self-checking bench for the questionable status tree
`timescale 1ns/1ps
module questionable_status_tree_tb;
	logic clk, nrst, fan_fault, clear_status, device_clear, req_valid, req_write, req_output;
	logic [1:0] constant_voltage, constant_current, overvoltage_trip;
	logic [2:0] req_sel;
	logic [15:0] req_wdata, rsp_rdata;
	logic rsp_valid, questionable_summary_bit;
	logic [7:0] status_byte;
	logic [31:0] r;
	int err_total, comparisons, cyc, seed;
	qst_status_tree i_dut (.clk, .nrst, .constant_voltage, .constant_current, .overvoltage_trip,
		.fan_fault, .clear_status, .device_clear, .req_valid, .req_write, .req_sel, .req_output,
		.req_wdata, .rsp_valid, .rsp_rdata, .status_byte, .questionable_summary_bit);
	function automatic logic [15:0] reg_exp(logic cv, logic cc, logic ov);
		return {6'h00, ov, 7'h00, cv & cc, cc};
	endfunction
	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// request stays up; idle() releases it so back-to-back calls keep it high without a gap
	task automatic req(logic w, logic [2:0] s, logic o, logic [15:0] d);
		req_valid = 1'b1;
		req_write = w;
		req_sel = s;
		req_output = o;
		req_wdata = d;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic rd(logic [2:0] s, logic o, logic [15:0] exp);
		req(1'b0, s, o, 16'h0000);
		chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
		chk("rdata", rsp_rdata, exp);
	endtask
	task automatic idle(int n);
		req_valid = 1'b0;
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse_clear(logic dev);
		clear_status = !dev;
		device_clear = dev;
		@(posedge clk);
		@(negedge clk);
		clear_status = 1'b0;
		device_clear = 1'b0;
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			conclude;
		end
	end
	initial begin
		{nrst, fan_fault, clear_status, device_clear, req_valid, req_write, req_output} = 7'h00;
		{constant_voltage, constant_current, overvoltage_trip} = 6'h00;
		{req_sel, req_wdata} = 19'h0_0000;
		seed = 32'h2596;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		for (int i = 0; i < 8; i++) rd(i[2:0], 1'b0, 16'h0000);
		$display("reset values done");
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			req(1'b1, 3'(1 + 2 * (i % 3)), r[16], r[15:0]);
			rd(3'(1 + 2 * (i % 3)), r[16], r[15:0]);
			rd(3'(1 + 2 * (i % 3)), r[16], r[15:0]);
		end
		req(1'b1, 3'h1, 1'b0, 16'h0000);
		req(1'b1, 3'h0, 1'b0, 16'hffff);
		rd(3'h1, 1'b0, 16'h0000);
		rd(3'h0, 1'b0, 16'h0000);
		$display("enable masks done");
		req(1'b1, 3'h3, 1'b0, 16'h0006);
		req(1'b1, 3'h5, 1'b0, 16'h0203);
		req(1'b1, 3'h5, 1'b1, 16'h0203);
		req(1'b1, 3'h1, 1'b0, 16'h2010);
		constant_voltage = 2'b01;
		idle(2);
		constant_current = 2'b01;
		idle(8);
		chk("stb3", {15'h0000, status_byte[3]}, 16'h0001);
		chk("stb", {8'h00, status_byte}, 16'h0008);
		chk("qsum", {15'h0000, questionable_summary_bit}, 16'h0001);
		rd(3'h4, 1'b0, reg_exp(1'b1, 1'b1, 1'b0));
		rd(3'h4, 1'b0, 16'h0000);
		rd(3'h2, 1'b0, 16'h0002);
		rd(3'h0, 1'b0, 16'h2000);
		idle(6);
		chk("stb3", {15'h0000, status_byte[3]}, 16'h0000);
		chk("qsum", {15'h0000, questionable_summary_bit}, 16'h0000);
		overvoltage_trip = 2'b10;
		idle(8);
		rd(3'h4, 1'b1, reg_exp(1'b0, 1'b0, 1'b1));
		rd(3'h2, 1'b0, 16'h0004);
		rd(3'h0, 1'b0, 16'h2000);
		for (int m = 0; m < 4; m++) begin
			{constant_voltage[0], constant_current[0]} = 2'(m);
			idle(2);
			rd(3'h6, 1'b0, 16'(m));
		end
		idle(8);
		pulse_clear(1'b0);
		idle(8);
		$display("event chain done");
		fan_fault = 1'b1;
		idle(2);
		fan_fault = 1'b0;
		idle(8);
		pulse_clear(1'b1);
		idle(2);
		chk("stb3", {15'h0000, status_byte[3]}, 16'h0001);
		rd(3'h0, 1'b0, 16'h0010);
		fan_fault = 1'b1;
		idle(8);
		pulse_clear(1'b0);
		rd(3'h4, 1'b0, 16'h0000);
		chk("stb3", {15'h0000, status_byte[3]}, 16'h0000);
		rd(3'h0, 1'b0, 16'h0000);
		rd(3'h1, 1'b0, 16'h2010);
		idle(2);
		$display("fan and clear done");
		conclude;
	end
endmodule
